/* core/nibble_port_pkg.sv */
// constants, types and register map for the nibble port block
package nibble_port_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int NIBBLE_W = 4;
    localparam int ADDR_W   = 7;

    typedef logic [NIBBLE_W-1:0] nibble_t;
    typedef logic [ADDR_W-1:0]   addr_t;

    // ----------------------------------------
    // register file addresses
    // ----------------------------------------
    localparam addr_t PERIPHERAL_PIN_SELECT_ADDR = 7'h0b;
    localparam addr_t BIT_PORT_DIRECTION_ADDR    = 7'h2b;
    localparam addr_t GROUP_PORT_DIRECTION_ADDR  = 7'h2c;

    // ----------------------------------------
    // data memory addresses and banks
    // ----------------------------------------
    localparam addr_t     BIT_PORT_DATA_ADDR        = 7'h73;
    localparam addr_t     OPEN_DRAIN_GROUP_DATA_ADDR = 7'h70;
    localparam addr_t     INPUT_ONLY_DATA_ADDR      = 7'h71;
    localparam logic      DATA_BANK_ZERO            = 1'b0;
    localparam logic      DATA_BANK_ONE             = 1'b1;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int SERIAL_PIN_ENABLE_BIT     = 0;
    localparam int TIMER_OUTPUT_SELECT_BIT   = 3;
    localparam int FIRST_PUSHPULL_DIR_BIT    = 0;
    localparam int SECOND_PUSHPULL_DIR_BIT   = 1;
    localparam int OPEN_DRAIN_GROUP_DIR_BIT  = 2;
    localparam int SERIAL_CLOCK_PIN          = 0;
    localparam int SERIAL_OUT_PIN            = 1;
    localparam int SERIAL_IN_PIN             = 2;
    localparam int TIMER_OUT_PIN             = 3;

    // ----------------------------------------
    // reset values and masks
    // ----------------------------------------
    localparam nibble_t NIBBLE_ZERO        = 4'h0;
    localparam nibble_t GROUP_DIR_MASK     = 4'h7;
    localparam nibble_t INPUT_ONLY_MASK    = 4'h1;
    localparam logic    TIMER_OUT_RESET    = 1'b1;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic    req;
        logic    write;
        logic    rf_space;
        logic    bank;
        addr_t   addr;
        nibble_t wdata;
    } core_access_t;

    typedef struct packed {
        nibble_t value;
        logic    valid;
    } core_read_t;

    typedef struct packed {
        nibble_t out;
        nibble_t oe_n;
    } od_drive_t;

    typedef struct packed {
        logic sck_out;
        logic sck_internal;
        logic so_out;
        logic so_latch_load;
        logic so_latch_value;
    } serial_side_t;

    typedef struct packed {
        logic sck_in;
        logic si_in;
    } serial_pins_t;

    typedef struct packed {
        nibble_t    peripheral_pin_select;
        nibble_t    bit_port_direction;
        nibble_t    group_port_direction;
        nibble_t    bit_port_latch;
        nibble_t    group_port_latch;
        core_read_t read;
    } port_state_t;

endpackage

/* core/timer0_pin_toggle.sv */
// timer 0 output pin level: set on timer reset, toggled on modulo match
`timescale 1ns/100ps
module timer0_pin_toggle
    import nibble_port_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // timer events
    input  wire logic timer0_reset,
    input  wire logic timer0_match,
    // pin level
    output logic      timer0_toggle_output
);

    typedef struct packed {
        logic level;
    } toggle_state_t;

    toggle_state_t state;
    toggle_state_t next_state;

    // ----------------------------------------
    // next level
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        if (timer0_reset)
        begin
            next_state.level = TIMER_OUT_RESET;
        end
        else if (timer0_match)
        begin
            next_state.level = ~state.level;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state.level <= TIMER_OUT_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign timer0_toggle_output = state.level;

endmodule

/* core/nibble_port_pin_control.sv */
// bit port, open-drain group port, input-only pin and their control registers
// What this block does
// - bit port data register with latch at data address 73h, bank zero.
// - bit port and group port pins drive only as open-drain.
// - each bit port pin input when direction bit 0, output when 1.
// - bit port reads pin for inputs, latch for outputs.
// - reset clears bit port directions and latch.
// - switching a pin to input leaves its latch unchanged.
// - serial enable gives pins 0 to 2 to serial clock, out, in.
// - timer select drives pin 3 with the timer 0 output.
// - timer pin set on timer reset, toggled on each modulo match.
// - serial and timer pins read latch or pin by function.
// - group port data register with latch at data address 70h, bank one.
// - group port pins all follow group direction bit 2 at 2ch.
// - group port reads pins when input, drives and reads latch when output.
// - reset clears group direction bit and group latch.
// - input-only pin mapped at data address 71h, bank one.
// - input-only reads pin in bit 0, zeros above; writes ignored.
// - group direction register bits 0..2 writable, bit 3 reads 0, reset 0.
`timescale 1ns/100ps
module nibble_port_pin_control
    import nibble_port_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // core access
    input  wire core_access_t core_access,
    output core_read_t        core_read,
    // bit-programmable port pins
    input  wire nibble_t      bit_programmable_port_in,
    output od_drive_t         bit_programmable_port_drive,
    // open-drain group port pins
    input  wire nibble_t      open_drain_group_port_in,
    output od_drive_t         open_drain_group_port_drive,
    // input-only pin
    input  wire logic         input_only_pin,
    // serial peripheral
    input  wire serial_side_t serial_side,
    output serial_pins_t      serial_pins,
    output logic              serial_pin_enable,
    // timer 0
    input  wire logic         timer0_reset,
    input  wire logic         timer0_match,
    // push-pull group directions for other ports
    output logic              first_pushpull_group_dir,
    output logic              second_pushpull_group_dir
);

    // ----------------------------------------
    // state and internal signals
    // ----------------------------------------
    port_state_t state;
    port_state_t next_state;
    logic        timer0_toggle_output;
    logic        timer_output_select;
    logic        open_drain_group_dir;
    nibble_t     bit_read;
    nibble_t     bit_drive_en;
    nibble_t     bit_drive_val;
    logic        wr;
    logic        rd;

    // ----------------------------------------
    // timer output pin level
    // ----------------------------------------
    timer0_pin_toggle timer0_pin_toggle_inst (
        .clk                  (clk),
        .reset                (reset),
        .timer0_reset         (timer0_reset),
        .timer0_match         (timer0_match),
        .timer0_toggle_output (timer0_toggle_output)
    );

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    assign serial_pin_enable    = state.peripheral_pin_select[SERIAL_PIN_ENABLE_BIT];
    assign timer_output_select  = state.peripheral_pin_select[TIMER_OUTPUT_SELECT_BIT];
    assign open_drain_group_dir = state.group_port_direction[OPEN_DRAIN_GROUP_DIR_BIT];
    assign first_pushpull_group_dir  = state.group_port_direction[FIRST_PUSHPULL_DIR_BIT];
    assign second_pushpull_group_dir = state.group_port_direction[SECOND_PUSHPULL_DIR_BIT];

    // ----------------------------------------
    // bus strobes
    // ----------------------------------------
    assign wr = core_access.req & core_access.write;
    assign rd = core_access.req & ~core_access.write;

    // ----------------------------------------
    // serial inputs taken straight from the pins
    // ----------------------------------------
    assign serial_pins.sck_in = bit_programmable_port_in[SERIAL_CLOCK_PIN];
    assign serial_pins.si_in  = bit_programmable_port_in[SERIAL_IN_PIN];

    // ----------------------------------------
    // per-pin function, drive and read value
    // ----------------------------------------
    generate
        for (genvar i = 0; i < NIBBLE_W; i++)
        begin : g_bit_pin
            logic serial_owned;
            logic timer_owned;
            logic periph_val;
            logic periph_en;
            logic read_latch;
            always_comb
            begin
                serial_owned = serial_pin_enable && (i != TIMER_OUT_PIN);
                timer_owned  = timer_output_select && (i == TIMER_OUT_PIN);
                periph_val   = 1'b1;
                periph_en    = 1'b0;
                read_latch   = state.bit_port_direction[i];
                if (serial_owned)
                begin
                    if (i == SERIAL_CLOCK_PIN)
                    begin
                        periph_en  = serial_side.sck_internal;
                        periph_val = serial_side.sck_out;
                        read_latch = serial_side.sck_internal;
                    end
                    else if (i == SERIAL_OUT_PIN)
                    begin
                        periph_en  = 1'b1;
                        periph_val = serial_side.so_out;
                        read_latch = 1'b1;
                    end
                    else
                    begin
                        read_latch = 1'b0;
                    end
                end
                else if (timer_owned)
                begin
                    periph_en  = 1'b1;
                    periph_val = timer0_toggle_output;
                    read_latch = 1'b1;
                end
                if (serial_owned || timer_owned)
                begin
                    bit_drive_en[i]  = periph_en;
                    bit_drive_val[i] = periph_val;
                end
                else
                begin
                    bit_drive_en[i]  = state.bit_port_direction[i];
                    bit_drive_val[i] = state.bit_port_latch[i];
                end
                if (read_latch)
                begin
                    bit_read[i] = state.bit_port_latch[i];
                end
                else
                begin
                    bit_read[i] = bit_programmable_port_in[i];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // open-drain drivers
    // ----------------------------------------
    always_comb
    begin
        bit_programmable_port_drive.out  = NIBBLE_ZERO;
        bit_programmable_port_drive.oe_n = ~(bit_drive_en & ~bit_drive_val);
    end

    always_comb
    begin
        open_drain_group_port_drive.out = NIBBLE_ZERO;
        if (open_drain_group_dir)
        begin
            open_drain_group_port_drive.oe_n = state.group_port_latch;
        end
        else
        begin
            open_drain_group_port_drive.oe_n = ~NIBBLE_ZERO;
        end
    end

    // ----------------------------------------
    // register writes and read data
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.read.valid = rd;
        next_state.read.value = NIBBLE_ZERO;
        if (serial_side.so_latch_load)
        begin
            next_state.bit_port_latch[SERIAL_OUT_PIN] = serial_side.so_latch_value;
        end
        if (core_access.rf_space)
        begin
            case (core_access.addr)
                PERIPHERAL_PIN_SELECT_ADDR:
                begin
                    if (wr)
                    begin
                        next_state.peripheral_pin_select = core_access.wdata;
                    end
                    next_state.read.value = state.peripheral_pin_select;
                end
                BIT_PORT_DIRECTION_ADDR:
                begin
                    if (wr)
                    begin
                        next_state.bit_port_direction = core_access.wdata;
                    end
                    next_state.read.value = state.bit_port_direction;
                end
                GROUP_PORT_DIRECTION_ADDR:
                begin
                    if (wr)
                    begin
                        next_state.group_port_direction = core_access.wdata & GROUP_DIR_MASK;
                    end
                    next_state.read.value = state.group_port_direction;
                end
                default:
                begin
                    next_state.read.value = NIBBLE_ZERO;
                end
            endcase
        end
        else if (core_access.bank == DATA_BANK_ZERO)
        begin
            case (core_access.addr)
                BIT_PORT_DATA_ADDR:
                begin
                    if (wr)
                    begin
                        next_state.bit_port_latch = core_access.wdata;
                    end
                    next_state.read.value = bit_read;
                end
                default:
                begin
                    next_state.read.value = NIBBLE_ZERO;
                end
            endcase
        end
        else if (core_access.bank == DATA_BANK_ONE)
        begin
            case (core_access.addr)
                OPEN_DRAIN_GROUP_DATA_ADDR:
                begin
                    if (wr)
                    begin
                        next_state.group_port_latch = core_access.wdata;
                    end
                    if (open_drain_group_dir)
                    begin
                        next_state.read.value = state.group_port_latch;
                    end
                    else
                    begin
                        next_state.read.value = open_drain_group_port_in;
                    end
                end
                INPUT_ONLY_DATA_ADDR:
                begin
                    next_state.read.value = {{(NIBBLE_W-1){1'b0}}, input_only_pin}
                                          & INPUT_ONLY_MASK;
                end
                default:
                begin
                    next_state.read.value = NIBBLE_ZERO;
                end
            endcase
        end
        if (!rd)
        begin
            next_state.read.value = state.read.value;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state.peripheral_pin_select <= NIBBLE_ZERO;
            state.bit_port_direction    <= NIBBLE_ZERO;
            state.bit_port_latch        <= NIBBLE_ZERO;
            state.group_port_direction  <= NIBBLE_ZERO;
            state.group_port_latch      <= NIBBLE_ZERO;
            state.read.value            <= NIBBLE_ZERO;
            state.read.valid            <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // read answer
    // ----------------------------------------
    assign core_read = state.read;

endmodule

/* verification/nibble_port_assertions.sv */
// assertion checker for the nibble port block
`timescale 1ns/100ps
module nibble_port_assertions
    import nibble_port_pkg::*;
(
    // clock and reset
    input wire logic         clk,
    input wire logic         reset,
    // watched ports
    input wire core_access_t core_access,
    input wire core_read_t   core_read,
    input wire nibble_t      bit_programmable_port_in,
    input wire od_drive_t    bit_programmable_port_drive,
    input wire od_drive_t    open_drain_group_port_drive,
    input wire logic         input_only_pin,
    input wire serial_side_t serial_side,
    input wire serial_pins_t serial_pins,
    input wire logic         serial_pin_enable,
    input wire logic         first_pushpull_group_dir,
    input wire logic         second_pushpull_group_dir
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic    rd;
    logic    wrf;
    nibble_t bo;
    assign rd  = core_access.req && !core_access.write;
    assign wrf = core_access.req && core_access.write && core_access.rf_space;
    assign bo  = bit_programmable_port_drive.oe_n;

    chk_read_answer: assert property (rd |=> core_read.valid)
        else $error("read unanswered");
    chk_no_extra: assert property (!rd |=> !core_read.valid)
        else $error("valid without read");
    chk_od_only: assert property (
        (bit_programmable_port_drive.out | open_drain_group_port_drive.out) == 4'h0)
        else $error("pin driven high");
    chk_bit_inputs: assert property (
        wrf && core_access.addr == BIT_PORT_DIRECTION_ADDR && core_access.wdata[2:0] == 3'h0
        |=> serial_pin_enable || bo[2:0] == 3'h7)
        else $error("input pin driven");
    chk_serial_select: assert property (
        wrf && core_access.addr == PERIPHERAL_PIN_SELECT_ADDR
        |=> serial_pin_enable == $past(core_access.wdata[0]))
        else $error("serial enable wrong");
    chk_serial_copy: assert property (
        serial_pins == {bit_programmable_port_in[0], bit_programmable_port_in[2]})
        else $error("serial inputs wrong");
    chk_serial_drive: assert property (
        serial_pin_enable |-> bo[1] == serial_side.so_out && bo[2])
        else $error("serial drive wrong");
    chk_group_release: assert property (
        wrf && core_access.addr == GROUP_PORT_DIRECTION_ADDR && !core_access.wdata[2]
        |=> open_drain_group_port_drive.oe_n == 4'hf)
        else $error("group not released");
    chk_pushpull_dirs: assert property (
        wrf && core_access.addr == GROUP_PORT_DIRECTION_ADDR
        |=> {second_pushpull_group_dir, first_pushpull_group_dir}
        == $past(core_access.wdata[1:0]))
        else $error("push-pull dirs wrong");
    chk_input_only: assert property (
        rd && !core_access.rf_space && core_access.bank
        && core_access.addr == INPUT_ONLY_DATA_ADDR
        |=> core_read.value == {3'h0, $past(input_only_pin)})
        else $error("input-only read wrong");
endmodule

bind nibble_port_pin_control nibble_port_assertions nibble_port_assertions_inst (
    .clk, .reset, .core_access, .core_read, .bit_programmable_port_in,
    .bit_programmable_port_drive, .open_drain_group_port_drive, .input_only_pin,
    .serial_side, .serial_pins, .serial_pin_enable, .first_pushpull_group_dir,
    .second_pushpull_group_dir);

/* verification/port_pin_partner.sv */
// far-side pins: pull-ups with loads that pull low
`timescale 1ns/100ps
module port_pin_partner
    import nibble_port_pkg::*;
(
    // drives from the block
    input  wire od_drive_t bit_drive,
    input  wire od_drive_t group_drive,
    // loads pulling pins low
    input  wire nibble_t   bit_load,
    input  wire nibble_t   group_load,
    // pin levels
    output nibble_t        bit_level,
    output nibble_t        group_level
);
    // wired-and of pull-up, drain and load
    assign bit_level   = bit_drive.oe_n & ~bit_load;
    assign group_level = group_drive.oe_n & ~group_load;
endmodule

/* verification/test_nibble_port_pin_control.sv */
// self-checking bench for the nibble port block
`timescale 1ns/100ps
module test_nibble_port_pin_control
    import nibble_port_pkg::*;
;
    logic         clk, reset, input_only_pin, timer0_reset, timer0_match;
    logic         spe, pp0, pp1;
    core_access_t core_access;
    core_read_t   core_read;
    serial_side_t serial_side;
    serial_pins_t serial_pins;
    od_drive_t    bit_drive, group_drive;
    nibble_t      bit_level, group_level, bit_load, group_load;
    int           mismatches, n_checks;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    nibble_port_pin_control nibble_port_pin_control_inst (
        .clk(clk), .reset(reset), .core_access(core_access), .core_read(core_read),
        .bit_programmable_port_in(bit_level), .bit_programmable_port_drive(bit_drive),
        .open_drain_group_port_in(group_level), .open_drain_group_port_drive(group_drive),
        .input_only_pin(input_only_pin), .serial_side(serial_side),
        .serial_pins(serial_pins), .serial_pin_enable(spe), .timer0_reset(timer0_reset),
        .timer0_match(timer0_match), .first_pushpull_group_dir(pp0),
        .second_pushpull_group_dir(pp1));

    port_pin_partner port_pin_partner_inst (.bit_drive(bit_drive), .group_drive(group_drive),
        .bit_load(bit_load), .group_load(group_load), .bit_level(bit_level),
        .group_level(group_level));

    task automatic chk(input string what, input nibble_t seen, input nibble_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic w, rf, bk, input addr_t ad, input nibble_t d);
        @(posedge clk);
        core_access <= '{1'b1, w, rf, bk, ad, d};
        @(posedge clk);
        core_access.req <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wr(input logic rf, bk, input addr_t ad, input nibble_t d);
        acc(1'b1, rf, bk, ad, d);
    endtask

    task automatic rd(input logic rf, bk, input addr_t ad, input nibble_t exp, input string s);
        acc(1'b0, rf, bk, ad, 4'h0);
        chk(s, {3'h0, core_read.valid}, 4'h1);
        chk(s, core_read.value, exp);
    endtask

    task automatic pulse(input logic rst);
        @(posedge clk);
        timer0_reset <= rst;
        timer0_match <= !rst;
        @(posedge clk);
        timer0_reset <= 1'b0;
        timer0_match <= 1'b0;
        @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        mismatches = 0;
        n_checks = 0;
        reset = 1'b1;
        core_access = '0;
        serial_side = '0;
        input_only_pin = 1'b0;
        timer0_reset = 1'b0;
        timer0_match = 1'b0;
        bit_load = 4'h0;
        group_load = 4'h0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk("bit oe", bit_drive.oe_n, 4'hf);
        chk("group oe", group_drive.oe_n, 4'hf);
        rd(1'b1, 1'b0, BIT_PORT_DIRECTION_ADDR, 4'h0, "bit dir");
        rd(1'b1, 1'b0, GROUP_PORT_DIRECTION_ADDR, 4'h0, "group dir");
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'hf, "bit pins");
        $display("reset test done");
        wr(1'b1, 1'b1, BIT_PORT_DIRECTION_ADDR, 4'hf);
        chk("bit latch", bit_drive.oe_n, 4'h0);
        wr(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h5);
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h5, "bit latch");
        wr(1'b1, 1'b0, BIT_PORT_DIRECTION_ADDR, 4'h3);
        chk("bit mixed oe", bit_drive.oe_n, 4'hd);
        @(posedge clk) bit_load <= 4'h5;
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h9, "bit mixed");
        wr(1'b1, 1'b0, BIT_PORT_DIRECTION_ADDR, 4'h0);
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'ha, "bit inputs");
        wr(1'b1, 1'b0, BIT_PORT_DIRECTION_ADDR, 4'hf);
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h5, "latch kept");
        rd(1'b0, 1'b1, BIT_PORT_DATA_ADDR, 4'h0, "bank one");
        $display("bit port test done");
        wr(1'b0, 1'b1, OPEN_DRAIN_GROUP_DATA_ADDR, 4'ha);
        wr(1'b1, 1'b0, GROUP_PORT_DIRECTION_ADDR, 4'hf);
        rd(1'b1, 1'b0, GROUP_PORT_DIRECTION_ADDR, 4'h7, "group dir");
        chk("group oe", group_drive.oe_n, 4'ha);
        chk("pushpull", {2'h0, pp1, pp0}, 4'h3);
        @(posedge clk) group_load <= 4'hf;
        rd(1'b0, 1'b1, OPEN_DRAIN_GROUP_DATA_ADDR, 4'ha, "group latch");
        wr(1'b1, 1'b0, GROUP_PORT_DIRECTION_ADDR, 4'h0);
        @(posedge clk) group_load <= 4'h3;
        rd(1'b0, 1'b1, OPEN_DRAIN_GROUP_DATA_ADDR, 4'hc, "group pins");
        rd(1'b0, 1'b0, OPEN_DRAIN_GROUP_DATA_ADDR, 4'h0, "bank zero");
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clk) input_only_pin <= v[0];
            wr(1'b0, 1'b1, INPUT_ONLY_DATA_ADDR, 4'hf);
            rd(1'b0, 1'b1, INPUT_ONLY_DATA_ADDR, nibble_t'(v), "input only");
        end
        rd(1'b1, 1'b0, 7'h7f, 4'h0, "unmapped");
        $display("group and input test done");
        @(posedge clk) serial_side <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        bit_load <= 4'h0;
        wr(1'b1, 1'b0, BIT_PORT_DIRECTION_ADDR, 4'h0);
        wr(1'b1, 1'b0, PERIPHERAL_PIN_SELECT_ADDR, 4'h1);
        chk("serial oe", {1'b0, bit_drive.oe_n[2:0]}, 4'h6);
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'hd, "serial int");
        @(posedge clk) serial_side.sck_internal <= 1'b0;
        bit_load <= 4'h1;
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'hc, "serial ext");
        @(posedge clk) serial_side.so_latch_load <= 1'b1;
        @(posedge clk) serial_side.so_latch_load <= 1'b0;
        wr(1'b1, 1'b0, PERIPHERAL_PIN_SELECT_ADDR, 4'h0);
        wr(1'b1, 1'b0, BIT_PORT_DIRECTION_ADDR, 4'hf);
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h7, "shifted latch");
        wr(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h5);
        $display("serial test done");
        wr(1'b1, 1'b0, PERIPHERAL_PIN_SELECT_ADDR, 4'h8);
        pulse(1'b1);
        chk("timer set", {3'h0, bit_drive.oe_n[3]}, 4'h1);
        pulse(1'b0);
        chk("timer toggle", {3'h0, bit_drive.oe_n[3]}, 4'h0);
        pulse(1'b0);
        chk("timer toggle", {3'h0, bit_drive.oe_n[3]}, 4'h1);
        pulse(1'b0);
        chk("timer toggle", {3'h0, bit_drive.oe_n[3]}, 4'h0);
        pulse(1'b1);
        chk("timer set", {3'h0, bit_drive.oe_n[3]}, 4'h1);
        rd(1'b0, 1'b0, BIT_PORT_DATA_ADDR, 4'h5, "timer read");
        $display("timer test done");
        end_of_test();
    end
endmodule
